/* sequence_input_function_decoder.sv */
// Purpose: decode contact sequence inputs into indexer functions
// Assumes: AHB-Lite slave on CLK, synchronous active-low RESETN
// Notes: software writes pending settings; a restart makes them active
`timescale 1ns/1ps
`default_nettype none
module sequence_input_function_decoder (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [seqin_pkg::CONTACTS-1:0] CONTACT_CLOSED,
  output var seqin_pkg::funcs_s FUNCS
);
  import seqin_pkg::*;

  // ---------------------------------------------------------------
  // contact synchronisation
  // ---------------------------------------------------------------
  logic [CONTACTS-1:0] lvl;
  logic [CONTACTS-1:0] prv;

  contact_sync #(.WIDTH(CONTACTS)) u_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .async_in(CONTACT_CLOSED),
    .level(lvl),
    .level_prev(prv)
  );

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic ap_valid;
  logic wr_q;
  logic rd_q;
  logic rd_done_q;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] hrdata_q;
  logic restart;
  settings_s pend_q;
  settings_s act_q;
  funcs_s funcs_q;
  funcs_s funcs_d;
  logic [1:0] prime_cnt_q;
  logic primed;

  // only whole-word single transfers are expected; HSIZE is not checked
  assign ap_valid = HSEL & HREADY & HTRANS[1];
  // reads take one wait state so read data always comes from a flip-flop
  assign HREADYOUT = ~(rd_q & ~rd_done_q);
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_q;

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_done_q <= 1'b0;
      addr_q <= '0;
    end
    else
    begin
      rd_done_q <= rd_q & ~rd_done_q;
      if (HREADYOUT)
      begin
        wr_q <= ap_valid & HWRITE;
        rd_q <= ap_valid & ~HWRITE;
        if (ap_valid)
        begin
          addr_q <= HADDR[ADDR_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (rd_q & ~rd_done_q)
    begin
      case (addr_q)
        OFS_PENDING: hrdata_q <= {22'h0, pend_q};
        OFS_ACTIVE: hrdata_q <= {22'h0, act_q};
        OFS_STATUS: hrdata_q <= {22'h0, primed, funcs_q};
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // settings: pending copy and active copy
  // ---------------------------------------------------------------
  assign restart = wr_q & (addr_q == OFS_CONTROL) & HWDATA[CTRL_RESTART_BIT];

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      pend_q <= SETTINGS_RESET;
    end
    else if (wr_q && addr_q == OFS_PENDING)
    begin
      pend_q <= HWDATA[9:0];
    end
  end

  // a changed setting never disturbs running logic until restart
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      act_q <= SETTINGS_RESET;
    end
    else if (restart)
    begin
      act_q <= pend_q;
    end
  end

  // hold off edge detection until the sync chain has fresh samples
  always_ff @(posedge CLK)
  begin
    if (!RESETN || restart)
    begin
      prime_cnt_q <= 2'h0;
    end
    else if (!primed)
    begin
      prime_cnt_q <= prime_cnt_q + 2'h1;
    end
  end

  assign primed = (prime_cnt_q == PRIME_CYCLES);

  // ---------------------------------------------------------------
  // function decode
  // ---------------------------------------------------------------
  function automatic logic asserted(input logic [1:0] s, input logic lv);
    asserted = (s == SET_CLOSED) ? lv : ((s == SET_OPEN) ? ~lv : 1'b0);
  endfunction : asserted

  logic mode_now;
  logic rst_edge;
  logic table_select_bit1_bit;

  always_comb
  begin
    case (act_q.mode_input_setting)
      SET_CLOSED: mode_now = lvl[IN_MODE];
      SET_OPEN: mode_now = ~lvl[IN_MODE];
      SET_FORCE_A: mode_now = 1'b0;
      default: mode_now = 1'b1;
    endcase
  end

  always_comb
  begin
    case (act_q.table_reset_setting)
      SET_CLOSED: rst_edge = lvl[IN_RST] & ~prv[IN_RST];
      SET_OPEN: rst_edge = ~lvl[IN_RST] & prv[IN_RST];
      default: rst_edge = 1'b0;
    endcase
  end

  always_comb
  begin
    if (act_q.select1_setting == SET_FORCE_A)
    begin
      table_select_bit1_bit = 1'b1;
    end
    else
    begin
      table_select_bit1_bit = asserted(act_q.select1_setting, lvl[IN_TABLE_SELECT_BIT1]);
    end
  end

  always_comb
  begin
    funcs_d = FUNCS_RESET;
    funcs_d.mode1 = mode_now;
    // settings 2 and 3 make asserted() zero, so nothing ever starts
    funcs_d.table_run = ~mode_now
      & asserted(act_q.run_halt_setting, lvl[IN_RUN]);
    funcs_d.homing_start = mode_now
      & asserted(act_q.run_halt_setting, lvl[IN_RUN]);
    funcs_d.table_reset = ~mode_now & primed & rst_edge;
    funcs_d.jog_forward = mode_now
      & asserted(act_q.table_reset_setting, lvl[IN_RST]);
    if (act_q.select0_setting == SET_FORCE_A)
    begin
      funcs_d.table_select[0] = ~mode_now;
    end
    else
    begin
      funcs_d.table_select[0] = ~mode_now
        & asserted(act_q.select0_setting, lvl[IN_TABLE_SELECT_BIT0]);
    end
    funcs_d.jog_reverse = mode_now
      & asserted(act_q.select0_setting, lvl[IN_TABLE_SELECT_BIT0]);
    funcs_d.table_select[1] = ~mode_now & table_select_bit1_bit;
    funcs_d.jog_speed_select_bit0 = mode_now & table_select_bit1_bit;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN || restart)
    begin
      funcs_q <= FUNCS_RESET;
    end
    else
    begin
      funcs_q <= funcs_d;
    end
  end

  assign FUNCS = funcs_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  sequence close_edge_s;
    !lvl[IN_RST] ##1 lvl[IN_RST];
  endsequence

  sequence open_edge_s;
    lvl[IN_RST] ##1 !lvl[IN_RST];
  endsequence

  restart_apply_a: assert property (restart |=> act_q == $past(pend_q))
    else $error("active settings not loaded at restart");

  settings_hold_a: assert property (!restart |=> $stable(act_q))
    else $error("active settings changed without restart");

  mode_select_a: assert property (!restart |=> FUNCS.mode1 == $past(
    act_q.mode_input_setting == SET_FORCE_B
    || (act_q.mode_input_setting == SET_CLOSED && lvl[IN_MODE])
    || (act_q.mode_input_setting == SET_OPEN && !lvl[IN_MODE])))
    else $error("mode decode wrong");

  run_closed_a: assert property (!restart && act_q.run_halt_setting == SET_CLOSED
    |=> (FUNCS.table_run | FUNCS.homing_start) == $past(lvl[IN_RUN]))
    else $error("run or homing not following closed contact");

  run_open_a: assert property (!restart && act_q.run_halt_setting == SET_OPEN
    |=> (FUNCS.table_run | FUNCS.homing_start) == !$past(lvl[IN_RUN]))
    else $error("run or homing not following open contact");

  run_never_a: assert property (act_q.run_halt_setting[1]
    |=> !FUNCS.table_run && !FUNCS.homing_start)
    else $error("run or homing started while disabled");

  reset_close_a: assert property ((close_edge_s ##0 (!restart && !mode_now && primed
    && act_q.table_reset_setting == SET_CLOSED)) |=> FUNCS.table_reset)
    else $error("closing edge missed table reset");

  reset_open_a: assert property ((open_edge_s ##0 (!restart && !mode_now && primed
    && act_q.table_reset_setting == SET_OPEN)) |=> FUNCS.table_reset)
    else $error("opening edge missed table reset");

  reset_pulse_a: assert property (FUNCS.table_reset |=> !FUNCS.table_reset)
    else $error("table reset longer than one cycle");

  jog_fwd_a: assert property (!restart && mode_now && !act_q.table_reset_setting[1]
    |=> FUNCS.jog_forward == $past(asserted(act_q.table_reset_setting, lvl[IN_RST])))
    else $error("forward jog wrong");

  reset_ignore_a: assert property (act_q.table_reset_setting[1]
    |=> !FUNCS.table_reset && !FUNCS.jog_forward)
    else $error("reset pin not ignored");

  table_select_bit0_force_a: assert property (!restart && act_q.select0_setting[1]
    |=> FUNCS.table_select[0] == ($past(!act_q.select0_setting[0]) && !FUNCS.mode1)
    && !FUNCS.jog_reverse)
    else $error("select bit 0 forcing wrong");

  table_select_bit0_level_a: assert property (!restart && !act_q.select0_setting[1]
    |=> (FUNCS.table_select[0] | FUNCS.jog_reverse)
    == ($past(lvl[IN_TABLE_SELECT_BIT0]) ^ $past(act_q.select0_setting[0])))
    else $error("select bit 0 or reverse jog wrong");

  table_select_bit1_force_a: assert property (!restart && act_q.select1_setting[1]
    |=> (FUNCS.table_select[1] | FUNCS.jog_speed_select_bit0)
    == $past(!act_q.select1_setting[0]))
    else $error("select bit 1 forcing wrong");

  table_select_bit1_share_a: assert property (FUNCS.mode1
    |-> !FUNCS.table_select[1] && !FUNCS.table_select[0])
    else $error("table bits active in mode 1");
endmodule : sequence_input_function_decoder
`default_nettype wire

/* seqin_pkg.sv */
// Purpose: shared constants and carriers for the sequence input function decoder
// Assumes: AHB-Lite register slave, 32-bit data, one word per register
// Notes: setting fields are two bits wide, so only the values 0 to 3 exist
`default_nettype none
package seqin_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, low 12 address bits decoded)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00C;
  localparam int CTRL_RESTART_BIT = 0;
  localparam int STATUS_PRIMED_BIT = 9;
  // ---------------------------------------------------------------
  // setting encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SET_CLOSED = 2'h0;
  localparam logic [1:0] SET_OPEN = 2'h1;
  localparam logic [1:0] SET_FORCE_A = 2'h2;
  localparam logic [1:0] SET_FORCE_B = 2'h3;
  // ---------------------------------------------------------------
  // contact input positions
  // ---------------------------------------------------------------
  localparam int CONTACTS = 5;
  localparam int IN_MODE = 0;
  localparam int IN_RUN = 1;
  localparam int IN_RST = 2;
  localparam int IN_TABLE_SELECT_BIT0 = 3;
  localparam int IN_TABLE_SELECT_BIT1 = 4;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  // cycles after reset or restart before edges on the reset pin count
  localparam logic [1:0] PRIME_CYCLES = 2'h3;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] select1_setting;
    logic [1:0] select0_setting;
    logic [1:0] table_reset_setting;
    logic [1:0] run_halt_setting;
    logic [1:0] mode_input_setting;
  } settings_s;
  localparam settings_s SETTINGS_RESET = 10'h000;
  typedef struct packed {
    logic jog_speed_select_bit0;
    logic [1:0] table_select;
    logic jog_reverse;
    logic jog_forward;
    logic table_reset;
    logic homing_start;
    logic table_run;
    logic mode1;
  } funcs_s;
  localparam funcs_s FUNCS_RESET = 9'h000;
endpackage : seqin_pkg
`default_nettype wire

/* contact_sync.sv */
// Purpose: two-stage synchroniser plus previous-sample register per contact
// Assumes: contacts are asynchronous levels, 1 = closed
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module contact_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] level_prev
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign level_prev = prev_q;
endmodule : contact_sync
`default_nettype wire

/* contact_bank.sv */
// Purpose: switch bank that opens and closes the sequence contacts
// Assumes: one clock; a requested pattern is reached lag + 1 cycles after it is set
// Notes: the lag stands for slow mechanical operation of the switches
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
  input wire logic clk,
  input wire logic [4:0] want,
  input wire logic [2:0] lag,
  output logic [4:0] closed
);
  logic [2:0] wait_q;
  initial
  begin
    closed = 5'h00;
    wait_q = 3'h0;
  end
  // all contacts move together, so a pattern never shows half applied
  always @(posedge clk)
  begin
    if (want == closed)
      wait_q <= 3'h0;
    else if (wait_q >= lag)
    begin
      closed <= want;
      wait_q <= 3'h0;
    end
    else
      wait_q <= wait_q + 3'h1;
  end
endmodule : contact_bank
`default_nettype wire

/* sequence_input_function_decoder_bench.sv */
// Purpose: self-checking bench for the sequence input function decoder
// Assumes: single AHB-Lite master, one slave, contacts from contact_bank
// Notes: every result is checked through register reads or the reset pulse
`timescale 1ns/1ps
`default_nettype none
module sequence_input_function_decoder_bench;
  import seqin_pkg::*;
  logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp, watch, rd_pend;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [2:0] lag;
  logic [4:0] want;
  logic [4:0] closed;
  logic [4:0] want_c;
  funcs_s funcs;
  settings_s s;
  settings_s old;
  int error_cnt;
  int checks;
  logic [31:0] exq[$];
  logic [11:0] adq[$];
  int pq[$];
  assign hready = hreadyout;
  sequence_input_function_decoder uut (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .CONTACT_CLOSED(closed),
    .FUNCS(funcs));
  contact_bank switches (.clk(clk), .want(want), .lag(lag), .closed(closed));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // expected decode
  // ---------------------------------------------------------------
  function automatic logic act(input logic [1:0] set, input logic c);
    return !set[1] && (c ^ set[0]);
  endfunction : act
  function automatic logic held(input logic [1:0] set, input logic c);
    return (set == SET_FORCE_A) || act(set, c);
  endfunction : held
  function automatic funcs_s model(input settings_s t, input logic [4:0] c);
    funcs_s f;
    logic m;
    f = FUNCS_RESET;
    m = t.mode_input_setting[1] ? t.mode_input_setting[0] : act(t.mode_input_setting, c[IN_MODE]);
    f.mode1 = m;
    f.table_run = !m && act(t.run_halt_setting, c[IN_RUN]);
    f.homing_start = m && act(t.run_halt_setting, c[IN_RUN]);
    f.jog_forward = m && act(t.table_reset_setting, c[IN_RST]);
    f.jog_reverse = m && act(t.select0_setting, c[IN_TABLE_SELECT_BIT0]);
    f.table_select[0] = !m && held(t.select0_setting, c[IN_TABLE_SELECT_BIT0]);
    f.table_select[1] = !m && held(t.select1_setting, c[IN_TABLE_SELECT_BIT1]);
    f.jog_speed_select_bit0 = m && held(t.select1_setting, c[IN_TABLE_SELECT_BIT1]);
    return f;
  endfunction : model
  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    if (!wr)
    begin
      exq.push_back(d);
      adq.push_back(a);
    end
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
  endtask : bus
  // waits for the switches, then for the three-edge decode latency
  task automatic put(input logic [4:0] v);
    int n;
    n = 0;
    want <= v;
    @(posedge clk);
    while (closed !== v && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (closed !== v)
    begin
      error_cnt++;
      $display("BAD closed exp %h got %h", v, closed);
    end
    repeat (4) @(posedge clk);
  endtask : put
  task end_sim;
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // ---------------------------------------------------------------
  // monitor: read data and reset pulses against the noted results
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!resetn)
      rd_pend <= 1'b0;
    if (rd_pend && hreadyout && exq.size() > 0)
    begin
      checks++;
      if (hrdata !== exq[0] || hresp !== 1'b0)
      begin
        error_cnt++;
        $display("BAD HRDATA at %h exp %h got %h", adq[0], exq[0], hrdata);
      end
      if (adq[0] == OFS_STATUS)
      begin
        checks++;
        if (funcs !== exq[0][8:0])
        begin
          error_cnt++;
          $display("BAD FUNCS exp %h got %h", exq[0][8:0], funcs);
        end
      end
      void'(exq.pop_front());
      void'(adq.pop_front());
      rd_pend <= 1'b0;
    end
    if (hsel && htrans[1] && !hwrite && hreadyout)
      rd_pend <= 1'b1;
    if (watch && funcs.table_reset === 1'b1)
    begin
      checks++;
      if (pq.size() == 0)
      begin
        error_cnt++;
        $display("BAD table_reset exp 0 got 1");
      end
      else
        void'(pq.pop_front());
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    want = 5'h00;
    lag = 3'h0;
    watch = 1'b0;
    error_cnt = 0;
    checks = 0;
    old = SETTINGS_RESET;
    resetn = 1'b0;
    void'($urandom(32'h82E349B8));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, OFS_CONTROL, 32'h0);
    bus(1'b1, 12'h010, 32'hFFFFFFFF);
    bus(1'b0, 12'h010, 32'h0);
    // first four passes set every field to each code in turn
    for (int i = 0; i < 48; i++)
    begin
      s = settings_s'(10'($urandom));
      if (i < 4)
        s = settings_s'({5{i[1:0]}});
      lag <= 3'($urandom_range(3));
      bus(1'b1, OFS_PENDING, {22'h0, s});
      bus(1'b0, OFS_ACTIVE, {22'h0, old});
      bus(1'b0, OFS_PENDING, {22'h0, s});
      bus(1'b1, OFS_CONTROL, 32'h1 << CTRL_RESTART_BIT);
      want_c = 5'($urandom);
      put(want_c);
      bus(1'b0, OFS_ACTIVE, {22'h0, s});
      bus(1'b0, OFS_STATUS, {22'h0, 1'b1, model(s, want_c)});
      bus(1'b0, OFS_STATUS, {22'h0, 1'b1, model(s, want_c)});
      old = s;
    end
    // reset-pin edges in forced mode 0 and forced mode 1
    for (int m = 2; m < 4; m++)
    begin
      for (int r = 0; r < 4; r++)
      begin
        put(5'h00);
        bus(1'b1, OFS_PENDING, {26'h0, 2'(r), 2'h0, 2'(m)});
        bus(1'b1, OFS_CONTROL, 32'h1 << CTRL_RESTART_BIT);
        repeat (4) @(posedge clk);
        watch <= 1'b1;
        if (m == 2 && r == 0)
          pq.push_back(1);
        put(5'h04);
        if (m == 2 && r == 1)
          pq.push_back(1);
        put(5'h00);
        watch <= 1'b0;
        checks++;
        if (pq.size() != 0)
        begin
          error_cnt++;
          $display("BAD table_reset exp 1 got 0");
          pq.delete();
        end
      end
    end
    // a second hardware reset returns the settings in force to 0
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, OFS_ACTIVE, 32'h0);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule : sequence_input_function_decoder_bench
`default_nettype wire
